/* logic/abe_exec.sv */
// execution unit for arithmetic, multiply, skip, jump, call and branch
// assumes an apb master on clock; io_bits come from pins of another domain
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - subtract immediate with carry, six flags, one cycle
// - word add immediate, flags without half carry, two
// - word subtract immediate, five flags, two cycles
// - and immediate, zero/negative/overflow/sign, one cycle
// - or mask into register, four flags, one
// - test register against itself, value kept, one
// - signed by unsigned product to result register, two
// - fractional product shifted left one, two cycles
// - jump to pointer, upper pc cleared, two
// - far jump, upper pc from upper register
// - call to pointer pushes return, upper cleared
// - far call uses upper register, three cycles
// - skip next when registers equal, one to three
// - skip on register bit clear or set
// - skip on io bit, two to four cycles
// - branch on selected flag to pc plus k plus one
// - signed branches on negative xor overflow
// - unsigned branches on carry, flags unchanged
// - branches on global interrupt enable flag
// - branches on half carry, relative target
module abe_exec
  import abe_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] io_bits,
  output logic [21:0] pc_out,
  output logic [7:0] flags_out,
  output logic push_valid,
  output logic [21:0] push_addr,
  output logic busy
);
  abe_state_t st_reg;
  logic [2:0] cnt_reg;
  logic [8:0] ctrl_reg;
  logic [15:0] opd_reg, pair_reg, res_reg;
  logic [7:0] imm_reg, flags_reg;
  logic [21:0] pc_reg;
  logic [5:0] upper_reg;
  logic [2:0] cyc_reg;
  logic [7:0] io_s1, io_s2, io_s3, io_reg;
  logic push_reg;
  logic [21:0] push_addr_reg;
  logic acc, go;
  logic [4:0] op;
  logic [2:0] sel;
  logic [7:0] d, r, k8;
  logic [7:0] res8_next, flags_next;
  logic [15:0] pair_next, mul_next;
  logic [21:0] pc_next, rel_off;
  logic [2:0] cyc_next;
  logic wr8, wr16, wrm, push_next, cond, skip;
  logic [8:0] sub9;
  logic [4:0] subh;
  logic [16:0] sum17;
  logic signed [16:0] prod;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  // a new instruction waits while the previous one still runs
  assign acc = psel & penable;
  assign pready = !(st_reg == ST_EXEC && pwrite && paddr == ADDR_CTRL);
  assign go = acc & pready & pwrite & (paddr == ADDR_CTRL);
  assign op = pwdata[4:0];
  assign sel = pwdata[CTRL_SEL_LSB +: 3];

  // read mux and unmapped address answer
  always_comb begin
    prdata = 32'h00000000;
    pslverr = 1'b0;
    if (paddr == ADDR_CTRL) begin
      prdata = {23'h000000, ctrl_reg};
    end else if (paddr == ADDR_OPD) begin
      prdata = {16'h0000, opd_reg};
    end else if (paddr == ADDR_IMM) begin
      prdata = {24'h000000, imm_reg};
    end else if (paddr == ADDR_PAIR) begin
      prdata = {16'h0000, pair_reg};
    end else if (paddr == ADDR_FLAGS) begin
      prdata = {24'h000000, flags_reg};
    end else if (paddr == ADDR_PC) begin
      prdata = {10'h000, pc_reg};
    end else if (paddr == ADDR_UPPER) begin
      prdata = {26'h0000000, upper_reg};
    end else if (paddr == ADDR_RES) begin
      prdata = {16'h0000, res_reg};
    end else if (paddr == ADDR_STAT) begin
      prdata = {28'h0000000, cyc_reg, busy};
    end else begin
      pslverr = acc;
    end
  end

  // ----------------------------------------------------------------
  // io bit input filter
  // ----------------------------------------------------------------
  // three stages; a bit changes once stages two and three agree
  always_ff @(posedge clock) begin
    if (!resetn) begin
      io_s1 <= 8'h00;
      io_s2 <= 8'h00;
      io_s3 <= 8'h00;
      io_reg <= 8'h00;
    end else begin
      io_s1 <= io_bits;
      io_s2 <= io_s1;
      io_s3 <= io_s2;
      io_reg <= (io_s2 & io_s3) | (io_reg & (io_s2 | io_s3));
    end
  end

  // ----------------------------------------------------------------
  // execute
  // ----------------------------------------------------------------
  assign d = opd_reg[7:0];
  assign r = opd_reg[15:8];
  assign k8 = imm_reg;
  assign rel_off = {{15{imm_reg[6]}}, imm_reg[6:0]};

  // result, flags, next pc and cycle count of the written instruction
  always_comb begin
    res8_next = d;
    pair_next = pair_reg;
    mul_next = res_reg;
    flags_next = flags_reg;
    pc_next = pc_reg + 22'h1;
    cyc_next = CYC_ALU;
    wr8 = 1'b0;
    wr16 = 1'b0;
    wrm = 1'b0;
    push_next = 1'b0;
    cond = 1'b0;
    skip = 1'b0;
    sub9 = {1'b0, d} - {1'b0, k8} - {8'h00, flags_reg[FLAG_C]};
    subh = {1'b0, d[3:0]} - {1'b0, k8[3:0]} - {4'h0, flags_reg[FLAG_C]};
    sum17 = (op == word_add_imm_op) ? {1'b0, pair_reg} + {11'h000, k8[5:0]}
                                    : {1'b0, pair_reg} - {11'h000, k8[5:0]};
    prod = $signed({{9{d[7]}}, d}) * $signed({9'h000, r});
    case (op)
      sub_imm_carry_op: begin
        res8_next = sub9[7:0];
        wr8 = 1'b1;
        flags_next[FLAG_C] = sub9[8];
        flags_next[FLAG_H] = subh[4];
        flags_next[FLAG_V] = (d[7] ^ k8[7]) & (d[7] ^ sub9[7]);
        flags_next[FLAG_N] = sub9[7];
        flags_next[FLAG_Z] = (sub9[7:0] == 8'h00) & flags_reg[FLAG_Z];
        flags_next[FLAG_S] = sub9[7] ^ flags_next[FLAG_V];
      end
      word_add_imm_op, word_sub_imm_op: begin
        pair_next = sum17[15:0];
        wr16 = 1'b1;
        cyc_next = CYC_WORD;
        if (op == word_add_imm_op) begin
          flags_next[FLAG_V] = ~pair_reg[15] & sum17[15];
          flags_next[FLAG_C] = ~sum17[15] & pair_reg[15];
        end else begin
          flags_next[FLAG_V] = pair_reg[15] & ~sum17[15];
          flags_next[FLAG_C] = sum17[15] & ~pair_reg[15];
        end
        flags_next[FLAG_N] = sum17[15];
        flags_next[FLAG_Z] = (sum17[15:0] == 16'h0000);
        flags_next[FLAG_S] = sum17[15] ^ flags_next[FLAG_V];
      end
      and_imm_op, set_mask_bits_op, zero_minus_test_op: begin
        if (op == and_imm_op) begin
          res8_next = d & k8;
        end else if (op == set_mask_bits_op) begin
          res8_next = d | k8;
        end else begin
          res8_next = d & d;
        end
        wr8 = (op != zero_minus_test_op);
        flags_next[FLAG_V] = 1'b0;
        flags_next[FLAG_N] = res8_next[7];
        flags_next[FLAG_S] = res8_next[7];
        flags_next[FLAG_Z] = (res8_next == 8'h00);
      end
      mixed_sign_multiply_op, mixed_sign_fraction_multiply_op: begin
        if (op == mixed_sign_multiply_op) begin
          mul_next = prod[15:0];
        end else begin
          mul_next = {prod[14:0], 1'b0};
        end
        wrm = 1'b1;
        cyc_next = CYC_MUL;
        flags_next[FLAG_C] = prod[15];
        flags_next[FLAG_Z] = (mul_next == 16'h0000);
      end
      pointer_jump_op: begin
        pc_next = {6'h00, pair_reg};
        cyc_next = CYC_JMP;
      end
      far_pointer_jump_op: begin
        pc_next = {upper_reg, pair_reg};
        cyc_next = CYC_JMP;
      end
      pointer_call_op: begin
        pc_next = {6'h00, pair_reg};
        push_next = 1'b1;
        cyc_next = CYC_CALL;
      end
      far_pointer_call_op: begin
        pc_next = {upper_reg, pair_reg};
        push_next = 1'b1;
        cyc_next = CYC_FAR_CALL;
      end
      compare_equal_skip_op, reg_bit_clear_skip_op, reg_bit_set_skip_op,
      io_bit_clear_skip_op, io_bit_set_skip_op: begin
        if (op == compare_equal_skip_op) begin
          skip = (d == r);
        end else if (op == reg_bit_clear_skip_op) begin
          skip = !r[sel];
        end else if (op == reg_bit_set_skip_op) begin
          skip = r[sel];
        end else if (op == io_bit_clear_skip_op) begin
          skip = !io_reg[sel];
        end else begin
          skip = io_reg[sel];
        end
        cyc_next = (op == io_bit_clear_skip_op || op == io_bit_set_skip_op)
                   ? CYC_IO_SKIP_BASE : CYC_SKIP_BASE;
        if (skip) begin
          pc_next = pc_reg + (ctrl_next_long() ? 22'h3 : 22'h2);
          cyc_next = cyc_next + (ctrl_next_long() ? 3'h2 : 3'h1);
        end
      end
      default: begin
        if (op == flag_set_branch_op) begin
          cond = flags_reg[sel];
        end else if (op == flag_clear_branch_op) begin
          cond = !flags_reg[sel];
        end else if (op == signed_ge_branch_op) begin
          cond = !(flags_reg[FLAG_N] ^ flags_reg[FLAG_V]);
        end else if (op == signed_lt_branch_op) begin
          cond = flags_reg[FLAG_N] ^ flags_reg[FLAG_V];
        end else if (op == unsigned_ge_branch_op) begin
          cond = !flags_reg[FLAG_C];
        end else if (op == unsigned_lt_branch_op) begin
          cond = flags_reg[FLAG_C];
        end else if (op == irq_on_branch_op) begin
          cond = flags_reg[FLAG_I];
        end else if (op == irq_off_branch_op) begin
          cond = !flags_reg[FLAG_I];
        end else if (op == half_carry_set_branch_op) begin
          cond = flags_reg[FLAG_H];
        end else if (op == half_carry_clear_branch_op) begin
          cond = !flags_reg[FLAG_H];
        end
        // unknown codes act as a one cycle no-op
        cyc_next = cond ? CYC_BR_TAKEN : CYC_BR_NOT;
        if (cond) begin
          pc_next = pc_reg + rel_off + 22'h1;
        end
      end
    endcase
  end

  // next-instruction length bit comes from the control word being written
  function automatic logic ctrl_next_long();
    return pwdata[CTRL_LONG_BIT];
  endfunction

  // ----------------------------------------------------------------
  // state: operand registers, written by software or by execution
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ctrl_reg <= 9'h000;
      opd_reg <= 16'h0000;
      imm_reg <= 8'h00;
      pair_reg <= 16'h0000;
      upper_reg <= 6'h00;
      res_reg <= 16'h0000;
    end else if (go) begin
      ctrl_reg <= pwdata[8:0];
      if (wr8) opd_reg[7:0] <= res8_next;
      if (wr16) pair_reg <= pair_next;
      if (wrm) res_reg <= mul_next;
    end else if (acc && pwrite) begin
      if (paddr == ADDR_OPD) opd_reg <= pwdata[15:0];
      if (paddr == ADDR_IMM) imm_reg <= pwdata[7:0];
      if (paddr == ADDR_PAIR) pair_reg <= pwdata[15:0];
      if (paddr == ADDR_UPPER) upper_reg <= pwdata[5:0];
    end
  end

  // flags and program counter
  always_ff @(posedge clock) begin
    if (!resetn) begin
      flags_reg <= FLAGS_RST;
      pc_reg <= PC_RST;
    end else if (go) begin
      flags_reg <= flags_next;
      pc_reg <= pc_next;
    end else if (acc && pwrite) begin
      if (paddr == ADDR_FLAGS) flags_reg <= pwdata[7:0];
      if (paddr == ADDR_PC) pc_reg <= pwdata[21:0];
    end
  end

  // return address push, one pulse after the call is taken
  always_ff @(posedge clock) begin
    if (!resetn) begin
      push_reg <= 1'b0;
      push_addr_reg <= 22'h000000;
    end else begin
      push_reg <= go & push_next;
      if (go && push_next) push_addr_reg <= pc_reg + 22'h1;
    end
  end

  // busy sequencer holds for the remaining instruction cycles
  always_ff @(posedge clock) begin
    if (!resetn) begin
      st_reg <= ST_IDLE;
      cnt_reg <= 3'h0;
      cyc_reg <= 3'h0;
    end else begin
      case (st_reg)
        ST_IDLE: begin
          if (go) begin
            cyc_reg <= cyc_next;
            cnt_reg <= cyc_next - 3'h1;
            if (cyc_next != 3'h1) st_reg <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          cnt_reg <= cnt_reg - 3'h1;
          if (cnt_reg == 3'h1) st_reg <= ST_IDLE;
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  assign busy = (st_reg == ST_EXEC);
  assign pc_out = pc_reg;
  assign flags_out = flags_reg;
  assign push_valid = push_reg;
  assign push_addr = push_addr_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sub_carry_cycle_a: assert property (@(posedge clock) disable iff (!resetn)
    go && op == sub_imm_carry_op |=> !busy && cyc_reg == 3'h1)
    else $error("subtract with carry not single cycle");
  word_busy_a: assert property (@(posedge clock) disable iff (!resetn)
    go && op == word_add_imm_op |=> busy ##1 !busy)
    else $error("word add not two cycles");
  logic_vclr_a: assert property (@(posedge clock) disable iff (!resetn)
    go && op == and_imm_op |=> !flags_reg[FLAG_V] && flags_reg[FLAG_C] == $past(flags_reg[FLAG_C]))
    else $error("and immediate flags wrong");
  test_keep_a: assert property (@(posedge clock) disable iff (!resetn)
    go && op == zero_minus_test_op |=> opd_reg == $past(opd_reg))
    else $error("test changed its register");
  mul_pair_a: assert property (@(posedge clock) disable iff (!resetn)
    go && op == mixed_sign_multiply_op |=> res_reg[15] == flags_reg[FLAG_C] ##1 !busy)
    else $error("multiply carry or timing wrong");
  jump_upper_a: assert property (@(posedge clock) disable iff (!resetn)
    go && op == pointer_jump_op |=> pc_reg[21:16] == 6'h00 && pc_reg[15:0] == $past(pair_reg))
    else $error("pointer jump target wrong");
  far_call_a: assert property (@(posedge clock) disable iff (!resetn)
    go && op == far_pointer_call_op |=> push_valid ##1 busy ##1 !busy)
    else $error("far call push or timing wrong");
  branch_time_a: assert property (@(posedge clock) disable iff (!resetn)
    go && op == flag_set_branch_op && !flags_reg[sel] |=> pc_reg == $past(pc_reg) + 22'h1 && !busy)
    else $error("untaken branch wrong");
endmodule

`default_nettype wire

/* logic/abe_pkg.sv */
// package for the alu and branch execution unit: offsets, fields, codes
// assumes a 32-bit apb slave with one aligned word per register
package abe_pkg;
  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OPD = 8'h04;
  localparam logic [7:0] ADDR_IMM = 8'h08;
  localparam logic [7:0] ADDR_PAIR = 8'h0c;
  localparam logic [7:0] ADDR_FLAGS = 8'h10;
  localparam logic [7:0] ADDR_PC = 8'h14;
  localparam logic [7:0] ADDR_UPPER = 8'h18;
  localparam logic [7:0] ADDR_RES = 8'h1c;
  localparam logic [7:0] ADDR_STAT = 8'h20;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_SEL_LSB = 5;
  localparam int CTRL_LONG_BIT = 8;
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [21:0] PC_RST = 22'h000000;
  // ----------------------------------------------------------------
  // cycle counts per instruction class
  // ----------------------------------------------------------------
  localparam logic [2:0] CYC_ALU = 3'h1;
  localparam logic [2:0] CYC_WORD = 3'h2;
  localparam logic [2:0] CYC_MUL = 3'h2;
  localparam logic [2:0] CYC_JMP = 3'h2;
  localparam logic [2:0] CYC_CALL = 3'h3;
  localparam logic [2:0] CYC_FAR_CALL = 3'h3;
  localparam logic [2:0] CYC_SKIP_BASE = 3'h1;
  localparam logic [2:0] CYC_IO_SKIP_BASE = 3'h2;
  localparam logic [2:0] CYC_BR_TAKEN = 3'h2;
  localparam logic [2:0] CYC_BR_NOT = 3'h1;
  // ----------------------------------------------------------------
  // operation codes
  // ----------------------------------------------------------------
  localparam logic [4:0] sub_imm_carry_op = 5'h00;
  localparam logic [4:0] word_add_imm_op = 5'h01;
  localparam logic [4:0] word_sub_imm_op = 5'h02;
  localparam logic [4:0] and_imm_op = 5'h03;
  localparam logic [4:0] set_mask_bits_op = 5'h04;
  localparam logic [4:0] zero_minus_test_op = 5'h05;
  localparam logic [4:0] mixed_sign_multiply_op = 5'h06;
  localparam logic [4:0] mixed_sign_fraction_multiply_op = 5'h07;
  localparam logic [4:0] pointer_jump_op = 5'h08;
  localparam logic [4:0] far_pointer_jump_op = 5'h09;
  localparam logic [4:0] pointer_call_op = 5'h0a;
  localparam logic [4:0] far_pointer_call_op = 5'h0b;
  localparam logic [4:0] compare_equal_skip_op = 5'h0c;
  localparam logic [4:0] reg_bit_clear_skip_op = 5'h0d;
  localparam logic [4:0] reg_bit_set_skip_op = 5'h0e;
  localparam logic [4:0] io_bit_clear_skip_op = 5'h0f;
  localparam logic [4:0] io_bit_set_skip_op = 5'h10;
  localparam logic [4:0] flag_set_branch_op = 5'h11;
  localparam logic [4:0] flag_clear_branch_op = 5'h12;
  localparam logic [4:0] signed_ge_branch_op = 5'h13;
  localparam logic [4:0] signed_lt_branch_op = 5'h14;
  localparam logic [4:0] unsigned_ge_branch_op = 5'h15;
  localparam logic [4:0] unsigned_lt_branch_op = 5'h16;
  localparam logic [4:0] irq_on_branch_op = 5'h17;
  localparam logic [4:0] irq_off_branch_op = 5'h18;
  localparam logic [4:0] half_carry_set_branch_op = 5'h19;
  localparam logic [4:0] half_carry_clear_branch_op = 5'h1a;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_EXEC = 2'b10} abe_state_t;
endpackage

/* tb/abe_pin_model.sv */
// far-side model: io pins seen by the skips, and the return stack
// assumes the execution unit's clock and reset; pins change after a rising edge
`timescale 1ns/10ps
`default_nettype none
module abe_pin_model (
  input wire logic clock,
  input wire logic resetn,
  input wire logic push_valid,
  input wire logic [21:0] push_addr,
  output logic [7:0] io_bits,
  output logic [7:0] push_count,
  output logic [21:0] last_push
);
  // pins keep their level until the bench moves them
  initial io_bits = 8'h00;
  task automatic set_pins(input logic [7:0] v);
    @(posedge clock);
    io_bits <= v;
  endtask
  // stack side: count pushes and keep the latest return address
  always_ff @(posedge clock) begin
    if (!resetn) begin
      push_count <= 8'h00;
      last_push <= 22'h000000;
    end else if (push_valid) begin
      push_count <= push_count + 8'h01;
      last_push <= push_addr;
    end
  end
endmodule
`default_nettype wire

/* tb/alu_and_branch_execution_test.sv */
// testbench for the execution unit: apb master, scenarios, verdict
// assumes abe_pkg and the pin model are compiled first
`timescale 1ns/10ps
`default_nettype none
module alu_and_branch_execution_test
  import abe_pkg::*;
;
  logic clock, resetn, psel, penable, pwrite, pready, pslverr, push_valid, busy, err;
  logic [7:0] paddr, io_bits, flags_out, push_count;
  logic [31:0] pwdata, prdata, rd;
  logic [21:0] pc_out, push_addr, last_push;
  int fails, checked, waits;

  abe_exec u_dut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .io_bits(io_bits), .pc_out(pc_out), .flags_out(flags_out),
    .push_valid(push_valid), .push_addr(push_addr), .busy(busy));
  abe_pin_model u_pins (.clock(clock), .resetn(resetn), .push_valid(push_valid),
    .push_addr(push_addr), .io_bits(io_bits), .push_count(push_count),
    .last_push(last_push));

  // free-running clock, 8 ns period
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic end_sim;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one transfer: setup, access held until pready, release after that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 100);
    r = prdata;
    e = pslverr;
    waits = n - 1;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 100) begin
      fails++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, exp, r);
  endtask

  task automatic load(input logic [31:0] opd, imm, pair, input logic [7:0] fl,
                      input logic [21:0] pc);
    wr(ADDR_OPD, opd);
    wr(ADDR_IMM, imm);
    wr(ADDR_PAIR, pair);
    wr(ADDR_FLAGS, {24'h0, fl});
    wr(ADDR_PC, {10'h0, pc});
    wr(ADDR_UPPER, 32'h2a);
  endtask

  // start an instruction, time its busy window, read its cycle count
  task automatic go(input logic [4:0] op, input logic [3:0] sl, input logic [2:0] cyc);
    int n;
    wr(ADDR_CTRL, {23'h0, sl, op});
    #1;
    n = 0;
    while (busy !== 1'b0 && n < 8) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("busy cycles", {29'h0, cyc} - 32'h1, n);
    if (n >= 8) begin
      end_sim();
    end
    rdchk("stat", ADDR_STAT, {28'h0, cyc, 1'b0});
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  // arithmetic and logic: result word, flags and cycle count
  task automatic alu(input logic [4:0] op, input logic [31:0] opd, imm, pair,
                     input logic [7:0] fl, efl, ea, input logic [31:0] ev,
                     input logic [2:0] cyc);
    load(opd, imm, pair, fl, 22'h0);
    go(op, 4'h0, cyc);
    chk("flags", {24'h0, efl}, {24'h0, flags_out});
    rdchk("result", ea, ev);
  endtask

  // program flow: new pc, flags untouched, return pushes of calls
  task automatic flow(input logic [4:0] op, input logic [3:0] sl, input logic [31:0] opd,
                      imm, input logic [7:0] fl, input logic [21:0] pcin, epc,
                      input logic [2:0] cyc);
    logic [7:0] n0;
    logic call;
    call = (op == pointer_call_op) || (op == far_pointer_call_op);
    load(opd, imm, 32'h1234, fl, pcin);
    n0 = push_count;
    go(op, sl, cyc);
    chk("pc", {10'h0, epc}, {10'h0, pc_out});
    chk("flags kept", {24'h0, fl}, {24'h0, flags_out});
    chk("pushes", {31'h0, call}, {24'h0, push_count - n0});
    if (call) begin
      chk("return", {10'h0, pcin + 22'h1}, {10'h0, last_push});
    end
  endtask

  // reset values and the unmapped-address answer
  task automatic reset_scn;
    chk("busy rst", 32'h0, {31'h0, busy});
    rdchk("flags rst", ADDR_FLAGS, 32'h0);
    rdchk("pc rst", ADDR_PC, 32'h0);
    apb(1'b0, 8'h24, 32'h0, rd, err);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
  endtask

  // arithmetic, logic and multiply results
  task automatic arith_scn;
    alu(sub_imm_carry_op, 32'h10, 32'h0f, 32'h0, 8'h03, 8'h22,
      ADDR_OPD, 32'h0, 3'h1);
    alu(word_add_imm_op, 32'h0, 32'h01, 32'hffff, 8'h20, 8'h23,
      ADDR_PAIR, 32'h0, 3'h2);
    alu(word_sub_imm_op, 32'h0, 32'h01, 32'h8000, 8'h00, 8'h18,
      ADDR_PAIR, 32'h7fff, 3'h2);
    alu(and_imm_op, 32'hf0, 32'h80, 32'h0, 8'h01, 8'h15,
      ADDR_OPD, 32'h80, 3'h1);
    alu(set_mask_bits_op, 32'h01, 32'h80, 32'h0, 8'h0a, 8'h14,
      ADDR_OPD, 32'h81, 3'h1);
    alu(zero_minus_test_op, 32'h80, 32'h0, 32'h0, 8'h03, 8'h15,
      ADDR_OPD, 32'h80, 3'h1);
    alu(mixed_sign_multiply_op, 32'h2ff, 32'h0, 32'h0, 8'h02, 8'h01,
      ADDR_RES, 32'hfffe, 3'h2);
    alu(mixed_sign_fraction_multiply_op, 32'h2ff, 32'h0, 32'h0, 8'h02, 8'h01,
      ADDR_RES, 32'hfffc, 3'h2);
  endtask

  // pointer jumps and calls
  task automatic jump_scn;
    flow(pointer_jump_op, 4'h0, 32'h0, 32'h0, 8'ha5,
      22'h3f0000, 22'h001234, 3'h2);
    flow(far_pointer_jump_op, 4'h0, 32'h0, 32'h0, 8'ha5,
      22'h000010, 22'h2a1234, 3'h2);
    flow(pointer_call_op, 4'h0, 32'h0, 32'h0, 8'ha5,
      22'h000005, 22'h001234, 3'h3);
    flow(far_pointer_call_op, 4'h0, 32'h0, 32'h0, 8'ha5,
      22'h100005, 22'h2a1234, 3'h3);
  endtask

  // register and io skips, then a control write stalled by a four cycle skip
  task automatic skip_scn;
    flow(compare_equal_skip_op, 4'h0, 32'h5555, 32'h0, 8'h00,
      22'h10, 22'h12, 3'h2);
    flow(compare_equal_skip_op, 4'h8, 32'h5455, 32'h0, 8'h00,
      22'h10, 22'h11, 3'h1);
    flow(reg_bit_clear_skip_op, 4'h3, 32'h0808, 32'h0, 8'h00,
      22'h10, 22'h11, 3'h1);
    flow(reg_bit_set_skip_op, 4'hb, 32'h0808, 32'h0, 8'h00,
      22'h10, 22'h13, 3'h3);
    flow(io_bit_clear_skip_op, 4'h0, 32'h0, 32'h0, 8'h00,
      22'h10, 22'h12, 3'h3);
    u_pins.set_pins(8'h80);
    repeat (4) @(posedge clock);
    flow(io_bit_set_skip_op, 4'hf, 32'h0, 32'h0, 8'h00,
      22'h10, 22'h13, 3'h4);
    flow(io_bit_clear_skip_op, 4'h7, 32'h0, 32'h0, 8'h00,
      22'h10, 22'h11, 3'h2);
    load(32'h0, 32'h0, 32'h0, 8'h00, 22'h10);
    wr(ADDR_CTRL, {23'h0, 4'hf, io_bit_set_skip_op});
    wr(ADDR_CTRL, {27'h0, 5'h1f});
    chk("wait states", 32'h1, waits);
    @(posedge clock);
    chk("pc after stall", 32'h14, {10'h0, pc_out});
  endtask

  // conditional branches, taken and not taken
  task automatic branch_scn;
    flow(flag_set_branch_op, 4'h6, 32'h0, 32'h7e, 8'h40,
      22'h10, 22'h0f, 3'h2);
    flow(flag_set_branch_op, 4'h6, 32'h0, 32'h7e, 8'h00,
      22'h10, 22'h11, 3'h1);
    flow(flag_clear_branch_op, 4'h6, 32'h0, 32'h7e, 8'h40,
      22'h10, 22'h11, 3'h1);
    flow(signed_ge_branch_op, 4'h0, 32'h0, 32'h7e, 8'h0c,
      22'h10, 22'h0f, 3'h2);
    flow(signed_lt_branch_op, 4'h0, 32'h0, 32'h7e, 8'h0c,
      22'h10, 22'h11, 3'h1);
    flow(signed_lt_branch_op, 4'h0, 32'h0, 32'h7e, 8'h04,
      22'h10, 22'h0f, 3'h2);
    flow(unsigned_ge_branch_op, 4'h0, 32'h0, 32'h7e, 8'h00,
      22'h10, 22'h0f, 3'h2);
    flow(unsigned_lt_branch_op, 4'h0, 32'h0, 32'h7e, 8'h00,
      22'h10, 22'h11, 3'h1);
    flow(unsigned_lt_branch_op, 4'h0, 32'h0, 32'h7e, 8'h01,
      22'h10, 22'h0f, 3'h2);
    flow(irq_on_branch_op, 4'h0, 32'h0, 32'h3f, 8'h80,
      22'h10, 22'h50, 3'h2);
    flow(irq_off_branch_op, 4'h0, 32'h0, 32'h3f, 8'h80,
      22'h10, 22'h11, 3'h1);
    flow(half_carry_set_branch_op, 4'h0, 32'h0, 32'h7e, 8'h20,
      22'h10, 22'h0f, 3'h2);
    flow(half_carry_clear_branch_op, 4'h0, 32'h0, 32'h7e, 8'h20,
      22'h10, 22'h11, 3'h1);
    flow(half_carry_clear_branch_op, 4'h0, 32'h0, 32'h7e, 8'h00,
      22'h10, 22'h0f, 3'h2);
    flow(5'h1f, 4'h0, 32'h0, 32'h7e, 8'h00,
      22'h10, 22'h11, 3'h1);
  endtask

  initial begin
    fails = 0;
    checked = 0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    reset_scn();
    arith_scn();
    jump_scn();
    skip_scn();
    branch_scn();
    end_sim();
  end
endmodule
`default_nettype wire
